// ---- fpq_pkg.sv ----
// Constants and types of the flash protect and query host controller
// Behaviour
// - Lock uses enter sequence then protect procedure; the controller has no lock command
// - Host exits secured region before main array access; the controller rejects READ/WRITE outside the first sector while secured
// - Reset command ends query mode
// - Write only with select, strobe low, output-enable high
package fpq_pkg;
	localparam int APB_AW = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA = 8'h08;
	localparam logic [7:0] OFS_RDATA = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_PINCTRL = 8'h14;
	localparam logic [3:0] PINCTRL_RST = 4'h9;
	localparam int PIN_VID = 0;
	localparam int PIN_WPN = 1;
	localparam int PIN_RSTN = 3;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_REJ = 2;
	localparam int ST_SEC = 3;
	localparam int ST_QRY = 4;
	localparam int FA_W = 22;
	localparam int FD_W = 16;
	localparam logic [6:0] FIRST_SECTOR_HI = 7'h00;
	localparam int CLK_MHZ = 10;
	localparam int T_WP_NS = 35;
	localparam int T_ACC_NS = 90;
	localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_CYC = 2;
	localparam logic [3:0] RD_WAIT = 4'(ACC_CYC + SYNC_CYC);
	localparam logic [3:0] WP_WAIT = 4'(WP_CYC);
	localparam logic [10:0] A_UNLK1 = 11'h555;
	localparam logic [10:0] A_UNLK2 = 11'h2aa;
	localparam logic [10:0] A_QUERY = 11'h055;
	localparam logic [7:0] D_UNLK1 = 8'haa;
	localparam logic [7:0] D_UNLK2 = 8'h55;
	localparam logic [7:0] D_SEC_ENTER = 8'h88;
	localparam logic [7:0] D_SEC_EXIT1 = 8'h90;
	localparam logic [7:0] D_SEC_EXIT2 = 8'h00;
	localparam logic [7:0] D_QUERY = 8'h98;
	localparam logic [7:0] D_RESET = 8'hf0;
	typedef enum logic [2:0] {
		CMD_WRITE, CMD_READ, CMD_SEC_ENTER, CMD_SEC_EXIT, CMD_QUERY,
		CMD_RESET
	} fpq_cmd_t;
endpackage

// ---- fpq_bus_if.sv ----
// Request and answer link between sequencer and bus cycle engine
`timescale 1ns/100ps
`default_nettype none
interface fpq_bus_if;
	logic req;
	logic wr;
	logic [21:0] addr;
	logic [15:0] wdata;
	logic ack;
	logic [15:0] rdata;
	modport ctl (output req, output wr, output addr, output wdata,
		input ack, input rdata);
	modport eng (input req, input wr, input addr, input wdata,
		output ack, output rdata);
endinterface // fpq_bus_if
`default_nettype wire

// ---- fpq_cycle.sv ----
// Asynchronous flash bus cycle engine: one read or write per request
`timescale 1ns/100ps
`default_nettype none
module fpq_cycle import fpq_pkg::*; (
	input wire logic clk_in,
	input wire logic arst_n_in,
	fpq_bus_if.eng bus,
	input wire logic [15:0] dq_in,
	output logic [21:0] addr_out,
	output logic [15:0] dq_out,
	output logic dq_oe_out,
	output logic ce_n_out,
	output logic oe_n_out,
	output logic we_n_out
);
	typedef enum logic [2:0] {
		E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_RDWAIT, E_DONE
	} fpq_eng_t;
	fpq_eng_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [15:0] dq_s1_r, dq_s2_r;
	logic [21:0] addr_r, addr_nxt;
	logic [15:0] dq_r, dq_nxt, rd_r, rd_nxt;
	logic oe_en_r, oe_en_nxt, ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt;
	logic ack_r, ack_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		addr_nxt = addr_r;
		dq_nxt = dq_r;
		rd_nxt = rd_r;
		oe_en_nxt = oe_en_r;
		ce_nxt = ce_r;
		oe_nxt = oe_r;
		we_nxt = we_r;
		ack_nxt = 1'b0;
		case (st_r)
			E_IDLE: begin
				if (bus.req) begin
					addr_nxt = bus.addr;
					ce_nxt = 1'b0;
					if (bus.wr) begin
						dq_nxt = bus.wdata;
						oe_en_nxt = 1'b1;
						oe_nxt = 1'b1;
						st_nxt = E_SETUP;
					end else begin
						oe_nxt = 1'b0;
						cnt_nxt = RD_WAIT;
						st_nxt = E_RDWAIT;
					end
				end
			end
			E_SETUP: begin
				we_nxt = 1'b0;
				cnt_nxt = WP_WAIT;
				st_nxt = E_STROBE;
			end
			E_STROBE: begin
				if (cnt_r <= 4'h1) begin
					we_nxt = 1'b1;
					st_nxt = E_HOLD;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			E_HOLD: begin
				ce_nxt = 1'b1;
				oe_en_nxt = 1'b0;
				ack_nxt = 1'b1;
				st_nxt = E_DONE;
			end
			E_RDWAIT: begin
				if (cnt_r <= 4'h1) begin
					rd_nxt = dq_s2_r;
					ce_nxt = 1'b1;
					oe_nxt = 1'b1;
					ack_nxt = 1'b1;
					st_nxt = E_DONE;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			E_DONE: st_nxt = E_IDLE;
			default: st_nxt = E_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r <= E_IDLE;
			cnt_r <= 4'h0;
			addr_r <= 22'h0;
			dq_r <= 16'h0;
			rd_r <= 16'h0;
			oe_en_r <= 1'b0;
			ce_r <= 1'b1;
			oe_r <= 1'b1;
			we_r <= 1'b1;
			ack_r <= 1'b0;
			dq_s1_r <= 16'h0;
			dq_s2_r <= 16'h0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			addr_r <= addr_nxt;
			dq_r <= dq_nxt;
			rd_r <= rd_nxt;
			oe_en_r <= oe_en_nxt;
			ce_r <= ce_nxt;
			oe_r <= oe_nxt;
			we_r <= we_nxt;
			ack_r <= ack_nxt;
			dq_s1_r <= dq_in;
			dq_s2_r <= dq_s1_r;
		end
	end

	assign bus.ack = ack_r;
	assign bus.rdata = rd_r;
	assign addr_out = addr_r;
	assign dq_out = dq_r;
	assign dq_oe_out = oe_en_r;
	assign ce_n_out = ce_r;
	assign oe_n_out = oe_r;
	assign we_n_out = we_r;
endmodule // fpq_cycle
`default_nettype wire

// ---- fpq_top.sv ----
// Host controller for flash protection, secured region and query mode
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fpq_top import fpq_pkg::*; (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic [21:0] FL_ADDR_OUT,
	input wire logic [15:0] FL_DQ_IN,
	output logic [15:0] FL_DQ_OUT,
	output logic FL_DQ_OE_OUT,
	output logic FL_CE_N_OUT,
	output logic FL_OE_N_OUT,
	output logic FL_WE_N_OUT,
	output logic FL_RESET_N_OUT,
	output logic FL_VID_EN_OUT,
	output logic FL_WP_N_OUT
);
	typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} fpq_seq_t;
	fpq_bus_if bus ();
	fpq_seq_t st_r, st_nxt;
	fpq_cmd_t cmd_r, cmd_nxt;
	logic [1:0] step_r, step_nxt;
	logic [21:0] addr_r, addr_nxt;
	logic [15:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0] pin_r, pin_nxt;
	logic done_r, done_nxt, rej_r, rej_nxt, sec_r, sec_nxt, qry_r, qry_nxt;
	logic req_r, req_nxt, wr_r, wr_nxt;
	logic [21:0] baddr_r, baddr_nxt;
	logic [15:0] bdata_r, bdata_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic setup, wr_acc, hit;
	logic [10:0] s_a;
	logic [7:0] s_d;
	logic s_last;

	// Address, data and end of each step of a command sequence
	always_comb begin
		s_a = A_UNLK1;
		s_d = D_UNLK1;
		s_last = 1'b0;
		case (cmd_r)
			CMD_SEC_ENTER, CMD_SEC_EXIT: begin
				if (step_r == 2'd1) begin
					s_a = A_UNLK2;
					s_d = D_UNLK2;
				end else if (step_r == 2'd2) begin
					s_d = (cmd_r == CMD_SEC_ENTER) ? D_SEC_ENTER
						: D_SEC_EXIT1;
					s_last = (cmd_r == CMD_SEC_ENTER);
				end else if (step_r == 2'd3) begin
					s_d = D_SEC_EXIT2;
					s_last = 1'b1;
				end
			end
			CMD_QUERY: begin
				s_a = A_QUERY;
				s_d = D_QUERY;
				s_last = 1'b1;
			end
			CMD_RESET: begin
				s_d = D_RESET;
				s_last = 1'b1;
			end
			default: s_last = 1'b1;
		endcase
	end

	assign setup = PSEL_IN && !PENABLE_IN;
	assign wr_acc = PSEL_IN && PENABLE_IN && pready_r && PWRITE_IN;
	assign hit = (PADDR_IN == OFS_CTRL) || (PADDR_IN == OFS_ADDR)
		|| (PADDR_IN == OFS_WDATA) || (PADDR_IN == OFS_RDATA)
		|| (PADDR_IN == OFS_STATUS) || (PADDR_IN == OFS_PINCTRL);

	always_comb begin
		st_nxt = st_r;
		cmd_nxt = cmd_r;
		step_nxt = step_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		pin_nxt = pin_r;
		done_nxt = done_r;
		rej_nxt = rej_r;
		sec_nxt = sec_r;
		qry_nxt = qry_r;
		req_nxt = req_r;
		wr_nxt = wr_r;
		baddr_nxt = baddr_r;
		bdata_nxt = bdata_r;
		prdata_nxt = prdata_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		// Register bus: answer prepared in setup, taken in access
		if (setup) begin
			pready_nxt = 1'b1;
			pslverr_nxt = !hit;
			prdata_nxt = 32'h0;
			if (PADDR_IN == OFS_ADDR) begin
				prdata_nxt = {10'h0, addr_r};
			end else if (PADDR_IN == OFS_WDATA) begin
				prdata_nxt = {16'h0, wdata_r};
			end else if (PADDR_IN == OFS_RDATA) begin
				prdata_nxt = {16'h0, rdata_r};
			end else if (PADDR_IN == OFS_STATUS) begin
				prdata_nxt = {27'h0, qry_r, sec_r, rej_r, done_r,
					(st_r != S_IDLE)};
			end else if (PADDR_IN == OFS_PINCTRL) begin
				prdata_nxt = {28'h0, pin_r};
			end
		end
		if (wr_acc) begin
			if (PADDR_IN == OFS_ADDR) begin
				addr_nxt = PWDATA_IN[21:0];
			end else if (PADDR_IN == OFS_WDATA) begin
				wdata_nxt = PWDATA_IN[15:0];
			end else if (PADDR_IN == OFS_PINCTRL) begin
				pin_nxt = PWDATA_IN[3:0];
			end else if (PADDR_IN == OFS_STATUS) begin
				if (PWDATA_IN[ST_DONE]) done_nxt = 1'b0;
				if (PWDATA_IN[ST_REJ]) rej_nxt = 1'b0;
			end else if (PADDR_IN == OFS_CTRL) begin
				if (st_r != S_IDLE || PWDATA_IN[2:0] > 3'(CMD_RESET)) begin
					rej_nxt = 1'b1;
				end else if (sec_r && PWDATA_IN[2:0] <= 3'(CMD_READ)
					&& addr_r[21:15] != FIRST_SECTOR_HI) begin
					rej_nxt = 1'b1;
				end else begin
					cmd_nxt = fpq_cmd_t'(PWDATA_IN[2:0]);
					step_nxt = 2'd0;
					st_nxt = S_ISSUE;
				end
			end
		end
		// Reset pin low returns the device to main array mapping and ends query mode
		if (!pin_r[PIN_RSTN]) begin
			sec_nxt = 1'b0;
			qry_nxt = 1'b0;
		end
		case (st_r)
			S_ISSUE: begin
				req_nxt = 1'b1;
				wr_nxt = (cmd_r != CMD_READ);
				baddr_nxt = {11'h0, s_a};
				bdata_nxt = {8'h0, s_d};
				if (cmd_r == CMD_WRITE || cmd_r == CMD_READ) begin
					baddr_nxt = addr_r;
					bdata_nxt = wdata_r;
				end
				st_nxt = S_WAIT;
			end
			S_WAIT: begin
				if (bus.ack) begin
					req_nxt = 1'b0;
					if (cmd_r == CMD_READ) rdata_nxt = bus.rdata;
					if (s_last) begin
						done_nxt = 1'b1;
						st_nxt = S_IDLE;
						if (cmd_r == CMD_SEC_ENTER) sec_nxt = 1'b1;
						if (cmd_r == CMD_SEC_EXIT) sec_nxt = 1'b0;
						if (cmd_r == CMD_QUERY) qry_nxt = 1'b1;
						if (cmd_r == CMD_RESET) qry_nxt = 1'b0;
					end else begin
						step_nxt = step_r + 2'd1;
						st_nxt = S_ISSUE;
					end
				end
			end
			default: st_nxt = st_nxt;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			st_r <= S_IDLE;
			cmd_r <= CMD_WRITE;
			step_r <= 2'd0;
			addr_r <= 22'h0;
			wdata_r <= 16'h0;
			rdata_r <= 16'h0;
			pin_r <= PINCTRL_RST;
			done_r <= 1'b0;
			rej_r <= 1'b0;
			sec_r <= 1'b0;
			qry_r <= 1'b0;
			req_r <= 1'b0;
			wr_r <= 1'b0;
			baddr_r <= 22'h0;
			bdata_r <= 16'h0;
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cmd_r <= cmd_nxt;
			step_r <= step_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			pin_r <= pin_nxt;
			done_r <= done_nxt;
			rej_r <= rej_nxt;
			sec_r <= sec_nxt;
			qry_r <= qry_nxt;
			req_r <= req_nxt;
			wr_r <= wr_nxt;
			baddr_r <= baddr_nxt;
			bdata_r <= bdata_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign bus.req = req_r;
	assign bus.wr = wr_r;
	assign bus.addr = baddr_r;
	assign bus.wdata = bdata_r;

	fpq_cycle u_cycle (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.bus(bus),
		.dq_in(FL_DQ_IN),
		.addr_out(FL_ADDR_OUT),
		.dq_out(FL_DQ_OUT),
		.dq_oe_out(FL_DQ_OE_OUT),
		.ce_n_out(FL_CE_N_OUT),
		.oe_n_out(FL_OE_N_OUT),
		.we_n_out(FL_WE_N_OUT)
	);

	assign PRDATA_OUT = prdata_r;
	assign PREADY_OUT = pready_r;
	assign PSLVERR_OUT = pslverr_r;
	assign FL_RESET_N_OUT = pin_r[PIN_RSTN];
	assign FL_VID_EN_OUT = pin_r[PIN_VID];
	assign FL_WP_N_OUT = pin_r[PIN_WPN];
endmodule // fpq_top
`default_nettype wire

// ---- fpq_chk.sv ----
// Port checker for the flash host controller
`timescale 1ns/100ps
`default_nettype none
module fpq_chk (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic [21:0] FL_ADDR_OUT,
	input wire logic FL_DQ_OE_OUT,
	input wire logic FL_CE_N_OUT,
	input wire logic FL_OE_N_OUT,
	input wire logic FL_WE_N_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	chk_we_qualified: assert property (!FL_WE_N_OUT |-> !FL_CE_N_OUT && FL_OE_N_OUT)
		else $error("write strobe without select");
	chk_we_width: assert property ($fell(FL_WE_N_OUT)
		|=> FL_WE_N_OUT && !FL_CE_N_OUT ##1 FL_CE_N_OUT)
		else $error("write pulse length wrong");
	chk_we_data: assert property (!FL_WE_N_OUT |-> FL_DQ_OE_OUT)
		else $error("write without driven data");
	chk_read_no_drive: assert property (!FL_OE_N_OUT |-> !FL_DQ_OE_OUT)
		else $error("data driven during read");
	chk_read_len: assert property ($fell(FL_OE_N_OUT) |=> !FL_OE_N_OUT[*2] ##1 FL_OE_N_OUT && FL_CE_N_OUT)
		else $error("read strobe length wrong");
	chk_addr_hold: assert property (!FL_CE_N_OUT && $past(!FL_CE_N_OUT) |-> $stable(FL_ADDR_OUT))
		else $error("address moved in cycle");
	chk_ce_gap: assert property ($rose(FL_CE_N_OUT) |=> FL_CE_N_OUT[*2])
		else $error("cycles too close");
	chk_apb_ready: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
		else $error("ready timing wrong");
	chk_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("error without ready");
	cover property ($fell(FL_WE_N_OUT));
	cover property ($fell(FL_OE_N_OUT));
	cover property (PSLVERR_OUT);
endmodule // fpq_chk
bind fpq_top fpq_chk u_chk (.*);
`default_nettype wire

// ---- fpq_flash_model.sv ----
// Behavioural flash device answering the host controller
`timescale 1ns/100ps
`default_nettype none
module fpq_flash_model import fpq_pkg::*; #(
	parameter bit LOCKED = 1'b1,
	parameter logic [15:0] SN_KEY = 16'h5a3c // Arbitrary value
) (
	input wire logic [21:0] addr_in,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic reset_n_in,
	input wire logic vid_en_in,
	input wire logic wp_n_in,
	input wire logic vcc_ok_in
);
	logic [15:0] mem [logic [21:0]];
	logic [15:0] smem [logic [6:0]];
	logic [15:0] rd;
	logic [15:0] last = 16'h0;
	logic sec = 1'b0;
	logic qry = 1'b0;
	logic aut = 1'b0;
	int st = 0;
	wire [7:0] c = dq_in[7:0];
	wire lo = addr_in[21:15] == 7'h00;
	wire grp = addr_in[21:17] == 5'h01 && !vid_en_in;
	wire prot = sec ? LOCKED : grp || (lo && !wp_n_in);
	always @(posedge we_n_in or negedge reset_n_in or negedge vcc_ok_in) begin
		if (!reset_n_in || !vcc_ok_in) begin
			sec = 1'b0;
			qry = 1'b0;
			aut = 1'b0;
			st = 0;
		end else if (!ce_n_in && oe_n_in) begin
			if (st == 3) begin
				if (!prot && sec) smem[addr_in[6:0]] = dq_in;
				else if (!prot) mem[addr_in] = dq_in;
				st = 0;
			end else if (c == D_RESET) begin
				qry = 1'b0;
				aut = 1'b0;
				st = 0;
			end else if (addr_in[10:0] == A_QUERY && c == D_QUERY) begin
				qry = 1'b1;
			end else if (st == 4) begin
				if (c == D_SEC_EXIT2) sec = 1'b0;
				st = 0;
			end else if (st == 2) begin
				if (c == D_SEC_ENTER) sec = 1'b1;
				if (c == D_SEC_EXIT1 && !sec) aut = 1'b1;
				st = c == 8'ha0 ? 3 : (c == D_SEC_EXIT1 && sec ? 4 : 0);
			end else if (st == 1) begin
				st = (c == D_UNLK2 && addr_in[10:0] == A_UNLK2) ? 2 : 0;
			end else begin
				st = (c == D_UNLK1 && addr_in[10:0] == A_UNLK1) ? 1 : 0;
			end
		end
	end
	always @* begin
		if (qry) begin
			case (addr_in[7:0])
				8'h10: rd = 16'h0051;
				8'h11: rd = 16'h0052;
				8'h12: rd = 16'h0059;
				8'h13: rd = 16'h0002;
				8'h15: rd = 16'h0040;
				default: rd = 16'h0000;
			endcase
		end else if (aut) begin
			rd = (addr_in[7:0] == 8'h03) ? {8'h00, LOCKED, 7'h00} : 16'h0000;
		end else if (sec && lo) begin
			if (addr_in[6:3] == 4'h0) rd = SN_KEY ^ {13'h0, addr_in[2:0]};
			else rd = smem.exists(addr_in[6:0]) ? smem[addr_in[6:0]] : 16'hffff;
		end else begin
			rd = mem.exists(addr_in) ? mem[addr_in] : 16'hffff;
		end
	end
	assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~last;
	always @(posedge oe_n_in) last = rd;
endmodule // fpq_flash_model
`default_nettype wire

// ---- tb_flash_protect_secure_region_query.sv ----
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
`default_nettype none
module tb_flash_protect_secure_region_query import fpq_pkg::*;;
	localparam logic [15:0] SN = 16'h5a3c; // Arbitrary value
	logic CLK_IN = 0, ARST_N_IN = 0, PSEL_IN = 0, PENABLE_IN = 0;
	logic PWRITE_IN = 0;
	logic [7:0] PADDR_IN = 0;
	logic [31:0] PWDATA_IN = 0, PRDATA_OUT, r;
	logic PREADY_OUT, PSLVERR_OUT, FL_DQ_OE_OUT, FL_CE_N_OUT, e;
	logic FL_OE_N_OUT, FL_WE_N_OUT, FL_RESET_N_OUT, FL_VID_EN_OUT, FL_WP_N_OUT;
	logic [21:0] FL_ADDR_OUT, a;
	logic [15:0] FL_DQ_IN, FL_DQ_OUT, mdq;
	logic [15:0] exp_mem [logic [21:0]];
	logic vcc_ok = 1'b1;
	int failures = 0, check_count = 0, i;
	assign FL_DQ_IN = FL_DQ_OE_OUT ? FL_DQ_OUT : mdq;
	initial forever #50 CLK_IN = ~CLK_IN;
	fpq_top dut (.*);
	fpq_flash_model #(.LOCKED(1'b1), .SN_KEY(SN)) u_flash (.addr_in(FL_ADDR_OUT),
		.dq_in(FL_DQ_OUT), .dq_out(mdq), .ce_n_in(FL_CE_N_OUT),
		.oe_n_in(FL_OE_N_OUT), .we_n_in(FL_WE_N_OUT),
		.reset_n_in(FL_RESET_N_OUT), .vid_en_in(FL_VID_EN_OUT),
		.wp_n_in(FL_WP_N_OUT), .vcc_ok_in(vcc_ok));
	task automatic final_report();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, s, x);
		end
	endtask
	task automatic tmo();
		failures++;
		$display("unexpected at %0t: wait ran out", $time);
		final_report();
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		@(posedge CLK_IN);
		PSEL_IN <= 1'b1;
		PENABLE_IN <= 1'b0;
		PWRITE_IN <= w;
		PADDR_IN <= ad;
		PWDATA_IN <= wd;
		@(posedge CLK_IN);
		PENABLE_IN <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge CLK_IN);
			if (PREADY_OUT === 1'b1) break;
		end
		if (n == 20) tmo();
		r = PRDATA_OUT;
		e = PSLVERR_OUT;
		PSEL_IN <= 1'b0;
		PENABLE_IN <= 1'b0;
	endtask
	task automatic wait_done();
		int n;
		for (n = 0; n < 50; n++) begin
			apb(0, OFS_STATUS, 0);
			if (r[ST_DONE] === 1'b1) break;
		end
		if (n == 50) tmo();
	endtask
	task automatic op(input logic [2:0] c);
		apb(1, OFS_CTRL, {29'h0, c});
		wait_done();
		apb(1, OFS_STATUS, 32'h6);
	endtask
	task automatic fw(input logic [21:0] ad, input logic [15:0] d);
		apb(1, OFS_ADDR, {10'h0, ad});
		apb(1, OFS_WDATA, {16'h0, d});
		op(CMD_WRITE);
	endtask
	task automatic fr(input logic [21:0] ad);
		apb(1, OFS_ADDR, {10'h0, ad});
		op(CMD_READ);
		apb(0, OFS_RDATA, 0);
	endtask
	task automatic rd_chk(input logic [21:0] ad);
		fr(ad);
		chk(r, exp_mem.exists(ad) ? {16'h0, exp_mem[ad]} : 32'hffff);
	endtask
	task automatic prog(input logic [21:0] ad, input logic ok);
		logic [15:0] d;
		d = 16'($urandom);
		fw({11'h0, A_UNLK1}, {8'h0, D_UNLK1});
		fw({11'h0, A_UNLK2}, {8'h0, D_UNLK2});
		fw({11'h0, A_UNLK1}, 16'h00a0);
		fw(ad, d);
		if (ok) exp_mem[ad] = d;
	endtask
	function automatic logic [15:0] cfi(input logic [7:0] ad);
		case (ad)
			8'h10: return 16'h0051;
			8'h11: return 16'h0052;
			8'h12: return 16'h0059;
			8'h13: return 16'h0002;
			8'h15: return 16'h0040;
			default: return 16'h0000;
		endcase
	endfunction
	initial begin
		repeat (90000) @(posedge CLK_IN);
		tmo();
	end
	initial begin
		repeat (6) @(posedge CLK_IN);
		ARST_N_IN <= 1'b1;
		r = $urandom(96);
		apb(0, OFS_PINCTRL, 0);
		chk(r, 32'h9);
		chk({29'h0, FL_VID_EN_OUT, FL_WP_N_OUT, FL_RESET_N_OUT}, 32'h5);
		apb(0, 8'h20, 0);
		chk(32'(e), 32'h1);
		apb(1, OFS_PINCTRL, 32'h8);
		op(CMD_QUERY);
		apb(0, OFS_STATUS, 0);
		chk(32'(r[ST_QRY]), 32'h1);
		for (i = 16; i <= 26; i++) begin
			fr(22'(i));
			chk(r, {16'h0, cfi(8'(i))});
		end
		op(CMD_RESET);
		apb(0, OFS_STATUS, 0);
		chk(32'(r[ST_QRY]), 32'h0);
		rd_chk(22'h0);
		a = {7'h05, 15'($urandom)};
		prog(a, 0);
		rd_chk(a);
		apb(1, OFS_PINCTRL, 32'h9);
		prog(a, 1);
		rd_chk(a);
		prog(22'h10, 0);
		rd_chk(22'h10);
		apb(1, OFS_PINCTRL, 32'hb);
		prog(22'h10, 1);
		rd_chk(22'h10);
		apb(1, OFS_PINCTRL, 32'ha);
		prog(a + 22'h1, 0);
		rd_chk(a + 22'h1);
		fw({11'h0, A_UNLK1}, {8'h0, D_UNLK1});
		fw({11'h0, A_UNLK2}, {8'h0, D_UNLK2});
		fw({11'h0, A_UNLK1}, {8'h0, D_SEC_EXIT1});
		fr(22'h3);
		chk(32'(r[7]), 32'h1);
		op(CMD_QUERY);
		fr(22'h10);
		chk(r, 32'h51);
		op(CMD_RESET);
		op(CMD_SEC_ENTER);
		for (i = 0; i < 8; i++) begin
			fr(22'(i));
			chk(r, {16'h0, SN ^ 16'(i)});
		end
		prog(22'h10, 0);
		fr(22'h10);
		chk(r, 32'hffff);
		apb(1, OFS_ADDR, 32'h8000);
		apb(1, OFS_CTRL, 32'(CMD_READ));
		apb(0, OFS_STATUS, 0);
		chk(32'(r[ST_REJ]), 32'h1);
		apb(1, OFS_STATUS, 32'h6);
		op(CMD_SEC_EXIT);
		rd_chk(22'h10);
		op(CMD_SEC_ENTER);
		apb(1, OFS_PINCTRL, 32'h2);
		apb(1, OFS_PINCTRL, 32'ha);
		apb(0, OFS_STATUS, 0);
		chk(32'(r[ST_SEC]), 32'h0);
		rd_chk(22'h10);
		vcc_ok <= 1'b0;
		prog(22'h20, 0);
		vcc_ok <= 1'b1;
		rd_chk(22'h20);
		prog(22'h20, 1);
		rd_chk(22'h20);
		apb(1, OFS_CTRL, 32'h7);
		apb(0, OFS_STATUS, 0);
		chk(32'(r[ST_REJ]), 32'h1);
		apb(1, OFS_STATUS, 32'h6);
		apb(1, OFS_CTRL, 32'(CMD_READ));
		apb(1, OFS_CTRL, 32'(CMD_READ));
		wait_done();
		chk(32'(r[ST_REJ]), 32'h1);
		final_report();
	end
endmodule // tb_flash_protect_secure_region_query
`default_nettype wire
